/* hdl/srx_map.svh */
`ifndef SRX_MAP_SVH
`define SRX_MAP_SVH

// register indices; byte address is four times the index
`define SRX_IDX_RATIO 10'h06C
`define SRX_IDX_EN 10'h071
`define SRX_IDX_TRIM 10'h073
`define SRX_IDX_STAT 10'h07C
`define SRX_IDX_FREQ 10'h07D
`define SRX_IDX_TRIMD 10'h07E

// reset values
`define SRX_RST_RATIO 32'h0001_0001
`define SRX_RST_EN 4'h3
`define SRX_RST_TRIM 32'h046A_AAAB

// field positions inside the ratio and status words
`define SRX_DEN_LSB 0
`define SRX_NUM_LSB 16
`define SRX_ST_VALID 0
`define SRX_ST_DZERO 1
`define SRX_ST_BUSY 2

// base x multiplier is scaled by eight, done as a shift
`define SRX_FREQ_SHIFT 3

// division walks one quotient bit per cycle
`define SRX_DIV_LAST 6'h32

// bus answers
`define SRX_RESP_OKAY 2'h0
`define SRX_RESP_SLVERR 2'h2

`endif

/* hdl/srx_pkg.sv */
package srx_pkg;

   // divider sequencer
   typedef enum logic {SRX_IDLE, SRX_DIVIDE} srx_calc_state_t;

   // all state of the frequency calculator
   typedef struct packed {
      srx_calc_state_t st;
      logic [5:0] cnt;
      logic [50:0] dvd;
      logic [16:0] rem;
      logic [50:0] quo;
      logic [15:0] den;
      logic busy;
      logic [31:0] freq;
      logic done;
      logic dz;
   } srx_calc_st_t;

   // all state of the register slice
   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_have;
      logic w_have;
      logic [9:0] aw_word;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [31:0] ratio;
      logic [3:0] en;
      logic [31:0] trim;
      logic [63:0] key;
      logic start;
      logic fvalid;
      logic [31:0] trimmed;
   } srx_regs_st_t;

endpackage

/* hdl/srx_freq_calc.sv */
`timescale 1ns/100ps
`include "srx_map.svh"

module srx_freq_calc (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // request
   input wire logic start,
   input wire logic [15:0] base_frequency_hz,
   input wire logic [15:0] base_freq_multiplier,
   input wire logic [15:0] fec_ratio_numerator,
   input wire logic [15:0] fec_ratio_denominator,
   // result
   output logic busy,
   output logic [31:0] freq_hz,
   output logic done,
   output logic den_zero
);

   srx_pkg::srx_calc_st_t s_r; // registered state
   srx_pkg::srx_calc_st_t s_nxt; // next state

   // serial restoring divide: slow, but tiny, and ratio writes are rare
   always_comb begin
      logic [16:0] r;
      logic [50:0] q;
      r = '0;
      q = '0;
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      unique case (s_r.st)
         srx_pkg::SRX_IDLE: begin
            if (start) begin
               // base x multiplier x 8 x numerator, then over denominator;
               // each factor is widened first so the 48-bit product cannot wrap
               s_nxt.dvd = (51'(base_frequency_hz) * 51'(base_freq_multiplier) * 51'(fec_ratio_numerator))
                           << `SRX_FREQ_SHIFT;
               s_nxt.den = fec_ratio_denominator;
               s_nxt.rem = '0;
               s_nxt.quo = '0;
               s_nxt.cnt = `SRX_DIV_LAST;
               if (fec_ratio_denominator == 16'h0000) begin
                  // no division possible: report zero and flag it
                  s_nxt.freq = '0;
                  s_nxt.dz = 1'b1;
                  s_nxt.done = 1'b1;
               end else begin
                  s_nxt.dz = 1'b0;
                  s_nxt.busy = 1'b1;
                  s_nxt.st = srx_pkg::SRX_DIVIDE;
               end
            end
         end
         srx_pkg::SRX_DIVIDE: begin
            r = {s_r.rem[15:0], s_r.dvd[50]};
            s_nxt.dvd = {s_r.dvd[49:0], 1'b0};
            if (r >= {1'b0, s_r.den}) begin
               s_nxt.rem = r - {1'b0, s_r.den};
               q = {s_r.quo[49:0], 1'b1};
            end else begin
               s_nxt.rem = r;
               q = {s_r.quo[49:0], 1'b0};
            end
            s_nxt.quo = q;
            s_nxt.cnt = s_r.cnt - 6'h01;
            if (s_r.cnt == 6'h00) begin
               // saturate rather than wrap an out-of-range setting
               s_nxt.freq = (q[50:32] != '0) ? 32'hFFFF_FFFF : q[31:0];
               s_nxt.done = 1'b1;
               s_nxt.busy = 1'b0;
               s_nxt.st = srx_pkg::SRX_IDLE;
            end
         end
      endcase
   end

   // state register, frozen while ce is low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign busy = s_r.busy;
   assign freq_hz = s_r.freq;
   assign done = s_r.done;
   assign den_zero = s_r.dz;

endmodule // srx_freq_calc

/* hdl/srx_regs.sv */
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "srx_map.svh"

module srx_regs (
   // clock, reset, clock enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite write address
   input wire logic [11:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [11:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // settings held by the rest of the synthesis control
   input wire logic [15:0] base_frequency_hz,
   input wire logic [15:0] base_freq_multiplier,
   // controls toward the synthesizers
   output logic [15:0] fourth_synth_ratio_top,
   output logic [15:0] fourth_synth_ratio_bottom,
   output logic [3:0] synth_enable,
   output logic [31:0] global_trim,
   // computed fourth synthesizer frequency
   output logic [31:0] synth3_freq_hz,
   output logic [31:0] synth3_trimmed_hz,
   output logic synth3_freq_valid,
   output logic synth3_den_zero
);

   // reset image of the whole state
   localparam srx_pkg::srx_regs_st_t RST_ST = '{
      ratio: `SRX_RST_RATIO,
      en: `SRX_RST_EN,
      trim: `SRX_RST_TRIM,
      default: '0
   };

   srx_pkg::srx_regs_st_t s_r; // registered state
   srx_pkg::srx_regs_st_t s_nxt; // next state

   logic calc_busy; // divider running
   logic [31:0] calc_freq; // last computed frequency
   logic calc_done; // one-cycle result pulse
   logic calc_dz; // last result had a zero denominator

   // merge new bytes into an old word under byte strobes
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // true for any index this slice answers
   function automatic logic reg_hit(input logic [9:0] w);
      return (w == `SRX_IDX_RATIO) || (w == `SRX_IDX_EN) || (w == `SRX_IDX_TRIM) ||
             (w == `SRX_IDX_STAT) || (w == `SRX_IDX_FREQ) || (w == `SRX_IDX_TRIMD);
   endfunction

   // scale f by (1 + t / 2^32) with t signed
   function automatic logic [31:0] trim_apply(input logic [31:0] f, input logic [31:0] t);
      logic signed [64:0] p;
      p = $signed({1'b0, f}) * $signed(t);
      return f + 32'(p >>> 32);
   endfunction

   // next-state logic: bus slave, register file, recompute trigger
   always_comb begin
      logic aw_hs;
      logic w_hs;
      logic [63:0] key;
      logic [9:0] rw;
      aw_hs = s_r.awready & s_axi_awvalid;
      w_hs = s_r.wready & s_axi_wvalid;
      key = {base_frequency_hz, base_freq_multiplier, s_r.ratio};
      rw = s_axi_araddr[11:2];
      s_nxt = s_r;
      s_nxt.start = 1'b0;

      // write response leaves when taken
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      // address and data may come in either order
      if (aw_hs) begin
         s_nxt.aw_have = 1'b1;
         s_nxt.aw_word = s_axi_awaddr[11:2];
      end
      if (w_hs) begin
         s_nxt.w_have = 1'b1;
         s_nxt.wdata = s_axi_wdata;
         s_nxt.wstrb = s_axi_wstrb;
      end
      // both halves present: commit the write and answer
      if (s_nxt.aw_have && s_nxt.w_have && !s_r.bvalid) begin
         s_nxt.aw_have = 1'b0;
         s_nxt.w_have = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = reg_hit(s_nxt.aw_word) ? `SRX_RESP_OKAY : `SRX_RESP_SLVERR;
         if (s_nxt.aw_word == `SRX_IDX_RATIO) begin
            // numerator and denominator share one word
            s_nxt.ratio = wmerge(s_r.ratio, s_nxt.wdata, s_nxt.wstrb);
         end
         if (s_nxt.aw_word == `SRX_IDX_EN && s_nxt.wstrb[0]) begin
            // only the low nibble is stored; upper bits are reserved
            s_nxt.en = s_nxt.wdata[3:0];
         end
         if (s_nxt.aw_word == `SRX_IDX_TRIM) begin
            s_nxt.trim = wmerge(s_r.trim, s_nxt.wdata, s_nxt.wstrb);
         end
         // status and frequency words are read only: writes are dropped
      end
      // one write at a time: stall both channels until the answer is taken
      s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
      s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;

      // read data leaves when taken
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      // read: data one cycle after the address is taken
      if (s_r.arready && s_axi_arvalid) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = reg_hit(rw) ? `SRX_RESP_OKAY : `SRX_RESP_SLVERR;
         s_nxt.rdata = '0;
         if (rw == `SRX_IDX_RATIO) begin
            s_nxt.rdata = s_r.ratio;
         end
         if (rw == `SRX_IDX_EN) begin
            s_nxt.rdata[3:0] = s_r.en;
         end
         if (rw == `SRX_IDX_TRIM) begin
            s_nxt.rdata = s_r.trim;
         end
         if (rw == `SRX_IDX_STAT) begin
            s_nxt.rdata[`SRX_ST_VALID] = s_r.fvalid;
            s_nxt.rdata[`SRX_ST_DZERO] = calc_dz;
            s_nxt.rdata[`SRX_ST_BUSY] = calc_busy;
         end
         if (rw == `SRX_IDX_FREQ) begin
            s_nxt.rdata = calc_freq;
         end
         if (rw == `SRX_IDX_TRIMD) begin
            s_nxt.rdata = s_r.trimmed;
         end
      end
      s_nxt.arready = !s_nxt.rvalid;

      // any change of inputs to the formula starts a new calculation;
      // a change seen while busy is picked up once the divider is free
      if (key != s_r.key && !calc_busy && !s_r.start) begin
         s_nxt.key = key;
         s_nxt.start = 1'b1;
         s_nxt.fvalid = 1'b0;
      end
      // result valid only if no newer request is pending or launched now
      if (calc_done && !s_r.start && !s_nxt.start) begin
         s_nxt.fvalid = 1'b1;
      end

      // the same trim scales every synthesizer; synth3 shown here
      s_nxt.trimmed = trim_apply(calc_freq, s_r.trim);
   end

   // state register, frozen while ce is low; reset gives unity ratio
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= RST_ST;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // ratio arithmetic for the fourth synthesizer
   srx_freq_calc u_calc (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .start(s_r.start),
      .base_frequency_hz(s_r.key[63:48]),
      .base_freq_multiplier(s_r.key[47:32]),
      .fec_ratio_numerator(s_r.key[`SRX_NUM_LSB +: 16]),
      .fec_ratio_denominator(s_r.key[`SRX_DEN_LSB +: 16]),
      .busy(calc_busy),
      .freq_hz(calc_freq),
      .done(calc_done),
      .den_zero(calc_dz)
   );

   // bus outputs straight from state
   assign s_axi_awready = s_r.awready;
   assign s_axi_wready = s_r.wready;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign s_axi_rvalid = s_r.rvalid;

   // controls toward the synthesizers
   assign fourth_synth_ratio_top = s_r.ratio[`SRX_NUM_LSB +: 16];
   assign fourth_synth_ratio_bottom = s_r.ratio[`SRX_DEN_LSB +: 16];
   assign synth_enable = s_r.en;
   assign global_trim = s_r.trim;
   assign synth3_freq_hz = calc_freq;
   assign synth3_trimmed_hz = s_r.trimmed;
   assign synth3_freq_valid = s_r.fvalid;
   assign synth3_den_zero = calc_dz;

endmodule // srx_regs

/* test/srx_regs_monitor.sv */
`timescale 1ns/100ps
module srx_regs_monitor (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // synthesizer controls
   input wire logic [15:0] fourth_synth_ratio_top,
   input wire logic [15:0] fourth_synth_ratio_bottom,
   input wire logic [3:0] synth_enable,
   input wire logic [31:0] global_trim,
   input wire logic [31:0] synth3_freq_hz,
   input wire logic synth3_freq_valid,
   input wire logic synth3_den_zero
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_ratio_reset: assert property (
      $rose(aresetn) |-> fourth_synth_ratio_top == 16'h0001 && fourth_synth_ratio_bottom == 16'h0001)
      else $error("ratio not unity after reset");
   a_en_reset: assert property (
      $rose(aresetn) |-> synth_enable == 4'h3)
      else $error("enable mask wrong after reset");
   a_trim_reset: assert property (
      $rose(aresetn) |-> global_trim == 32'h046A_AAAB)
      else $error("trim wrong after reset");
   // a zero denominator must never yield a quotient
   a_den_zero: assert property (
      synth3_freq_valid && $stable(fourth_synth_ratio_bottom) && fourth_synth_ratio_bottom == 16'h0000
      |-> synth3_freq_hz == 32'h0000_0000 && synth3_den_zero)
      else $error("zero denominator gave a frequency");
   // a new denominator drops valid, then the divider finishes in bounded time
   a_recalc_bound: assert property (
      $changed(fourth_synth_ratio_bottom) |-> ##[0:3] !synth3_freq_valid ##[1:80] synth3_freq_valid)
      else $error("frequency not recomputed in time");
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write response late");
   a_resp_clear: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not cleared");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
endmodule // srx_regs_monitor

bind srx_regs srx_regs_monitor u_srx_regs_monitor (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .fourth_synth_ratio_top(fourth_synth_ratio_top), .fourth_synth_ratio_bottom(fourth_synth_ratio_bottom),
   .synth_enable(synth_enable), .global_trim(global_trim), .synth3_freq_hz(synth3_freq_hz),
   .synth3_freq_valid(synth3_freq_valid), .synth3_den_zero(synth3_den_zero));

/* test/test_srx_regs.sv */
`timescale 1ns/100ps
`include "srx_map.svh"
module test_srx_regs;
   // settings from the rest of the synthesis control
   localparam logic [15:0] base_hz = 16'h9C40;
   localparam logic [15:0] mult = 16'h0798;
   // stimulus, driven on the rising edge
   logic aclk = '0, rstn = '0, awv = '0, wv = '0, bry = '0, arv = '0, rry = '0;
   logic [11:0] awa = '0, ara = '0;
   logic [31:0] wd = '0;
   logic [3:0] ws = '0;
   // observed outputs
   logic awr, wrd, bv, arr, rv, vld, dz;
   logic [1:0] br, rr;
   logic [31:0] rd, fq, tq, trm;
   logic [15:0] num, den;
   logic [3:0] en;
   int err_total = 0, checks = 0, cyc = 0;

   srx_regs u_srx_regs (.aclk(aclk), .aresetn(rstn), .ce(1'h1), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
      .s_axi_rvalid(rv), .s_axi_rready(rry), .base_frequency_hz(base_hz), .base_freq_multiplier(mult),
      .fourth_synth_ratio_top(num), .fourth_synth_ratio_bottom(den), .synth_enable(en), .global_trim(trm),
      .synth3_freq_hz(fq), .synth3_trimmed_hz(tq), .synth3_freq_valid(vld), .synth3_den_zero(dz));

   // 20 MHz clock
   always #25 aclk = ~aclk;

   // hang guard, far above the few hundred cycles needed
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         conclude();
      end
   end

   task automatic conclude();
      if (err_total == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask

   // expected frequency, kept wide so the product cannot wrap
   function automatic logic [31:0] ef(longint n, longint d);
      return d == 0 ? 32'h0000_0000 : longint'(base_hz) * mult * 8 * n / d;
   endfunction

   // expected trimmed frequency, signed trim in 2^-32 steps
   function automatic logic [31:0] et(logic [31:0] f, logic [31:0] t);
      longint fl;
      fl = f;
      return fl + ((fl * longint'($signed(t))) >>> 32);
   endfunction

   // one write; address and data released each when taken
   task automatic wr(input logic [9:0] i, input logic [31:0] d, input logic [3:0] s = 4'hF,
      input logic [1:0] er = `SRX_RESP_OKAY);
      bit a = 1'h1, w = 1'h1;
      @(posedge aclk);
      awa <= {i, 2'h0};
      wd <= d;
      ws <= s;
      awv <= 1'h1;
      wv <= 1'h1;
      bry <= 1'h1;
      do begin
         @(posedge aclk);
         a = a && !awr;
         w = w && !wrd;
         awv <= a;
         wv <= w;
      end while (a || w);
      do @(posedge aclk); while (!bv);
      bry <= 1'h0;
      chk("bresp", {30'h0, br}, {30'h0, er});
   endtask

   // one read, compared with what is expected
   task automatic rc(input logic [9:0] i, input logic [31:0] e, input logic [1:0] er = `SRX_RESP_OKAY);
      @(posedge aclk);
      ara <= {i, 2'h0};
      arv <= 1'h1;
      rry <= 1'h1;
      do @(posedge aclk); while (!arr);
      arv <= 1'h0;
      do @(posedge aclk); while (!rv);
      rry <= 1'h0;
      chk("rresp", {30'h0, rr}, {30'h0, er});
      chk("rdata", rd, e);
   endtask

   // wait for the divider; trimmed value lags by a cycle
   task automatic wait_freq();
      repeat (3) @(posedge aclk);
      do @(posedge aclk); while (!vld);
      repeat (2) @(posedge aclk);
   endtask

   task automatic t_reset();
      rc(`SRX_IDX_RATIO, 32'h0001_0001);
      chk("ratio ports", {num, den}, 32'h0001_0001);
      rc(`SRX_IDX_EN, 32'h0000_0003);
      rc(`SRX_IDX_TRIM, 32'h046A_AAAB);
      wait_freq();
      chk("freq", fq, ef(1, 1));
      chk("trimmed", tq, et(ef(1, 1), 32'h046A_AAAB));
   endtask

   // fec ratio, then byte-wise updates of each half
   task automatic t_fec();
      wr(`SRX_IDX_RATIO, 32'h00FF_00ED);
      chk("ratio ports", {num, den}, 32'h00FF_00ED);
      wait_freq();
      chk("freq", fq, ef(255, 237));
      rc(`SRX_IDX_STAT, 32'h0000_0001);
      wr(`SRX_IDX_RATIO, 32'h41BE_3B80, 4'h3);
      rc(`SRX_IDX_RATIO, 32'h00FF_3B80);
      wait_freq();
      chk("freq", fq, ef(255, 15232));
      wr(`SRX_IDX_RATIO, 32'h41BE_3B80, 4'hC);
      wait_freq();
      chk("freq", fq, ef(16830, 15232));
   endtask

   // a zero denominator must not divide
   task automatic t_dz();
      wr(`SRX_IDX_RATIO, 32'h0005_0000);
      wait_freq();
      chk("freq", fq, 32'h0000_0000);
      chk("den zero", {31'h0, dz}, 32'h0000_0001);
      rc(`SRX_IDX_STAT, 32'h0000_0003);
   endtask

   task automatic t_unity();
      wr(`SRX_IDX_RATIO, 32'h0001_0001);
      wait_freq();
      chk("freq", fq, ef(1, 1));
      chk("den zero", {31'h0, dz}, 32'h0000_0000);
      rc(`SRX_IDX_FREQ, ef(1, 1));
   endtask

   // negative trim pulls the frequency down
   task automatic t_trim();
      wr(`SRX_IDX_TRIM, 32'hFAFA_FAFB);
      chk("trim port", trm, 32'hFAFA_FAFB);
      repeat (3) @(posedge aclk);
      chk("trimmed", tq, et(ef(1, 1), 32'hFAFA_FAFB));
      rc(`SRX_IDX_TRIMD, et(ef(1, 1), 32'hFAFA_FAFB));
   endtask

   // each enable bit alone, then the reserved bits
   task automatic t_en();
      for (int n = 0; n < 4; n++) begin
         wr(`SRX_IDX_EN, 32'h0000_0001 << n, 4'h1);
         chk("enable", {28'h0, en}, 32'h0000_0001 << n);
      end
      wr(`SRX_IDX_EN, 32'h0000_00FF, 4'h1);
      rc(`SRX_IDX_EN, 32'h0000_000F);
   endtask

   // unmapped place refused, read-only place ignored
   task automatic t_bad();
      wr(10'h070, 32'h1234_5678, 4'hF, `SRX_RESP_SLVERR);
      rc(10'h070, 32'h0000_0000, `SRX_RESP_SLVERR);
      wr(`SRX_IDX_STAT, 32'hFFFF_FFFF);
      rc(`SRX_IDX_STAT, 32'h0000_0001);
   endtask

   initial begin
      repeat (6) @(posedge aclk);
      rstn <= 1'h1;
      t_reset();
      t_fec();
      t_dz();
      t_unity();
      t_trim();
      t_en();
      t_bad();
      conclude();
   end
endmodule // test_srx_regs
